// ### rtl/sfm_pkg.sv
package sfm_pkg;

	// Register map, byte address on the Wishbone bus
	localparam logic [7:0] SFM_CTRL_ADDR  = 8'h0c;
	localparam logic [7:0] SFM_CTRL_RESET = 8'h7f;

	// Field positions inside the control register
	localparam int SFM_ACTIVE_BIT = 7;
	localparam int SFM_TOP_BIT    = 6;

	// Countdown value at which the top bit is about to clear
	localparam logic [6:0] SFM_COUNT_EDGE = 7'h40;

	// Decrement interval in machine cycles
	localparam int SFM_STEP_CYCLES = 49152;

	// Reset pulse length, ns, and the clock period, ns
	localparam int SFM_PULSE_NS  = 500;
	localparam int SFM_CLK_NS    = 5;
	localparam int SFM_PULSE_CYC = SFM_PULSE_NS / SFM_CLK_NS;

	// Classic Wishbone request as seen by the slave
	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [7:0]  adr;
		logic [3:0]  sel;
		logic [31:0] dat;
	} sfm_wb_req_s;

endpackage

// ### rtl/sfm_pulse_gen.sv
// Stretches a one-cycle trigger into a fixed-length low-active reset pulse
module sfm_pulse_gen
	import sfm_pkg::*;
(
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic trigger_i,
	output logic      reset_n_o,
	output logic      busy_o
);

	logic [7:0] remain;

	// Load on trigger, count down to zero; re-trigger restarts the pulse
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			remain <= 8'h00;
		end else if (trigger_i) begin
			remain <= 8'(SFM_PULSE_CYC);
		end else if (remain != 8'h00) begin
			remain <= remain - 8'h01;
		end
	end

	// Registered so the pin never glitches from the counter compare
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			reset_n_o <= 1'b1;
		end else begin
			reset_n_o <= !(trigger_i || remain > 8'h01);
		end
	end

	assign busy_o = (remain != 8'h00);

endmodule

// ### rtl/sfm_watchdog.sv
// Behaviour
// - Countdown field decrements once every 49,152 machine cycles.
// - Active and count passing 40h to 3Fh starts a 500 ns reset pulse.
// - Timeouts follow from the step length and loaded count.
// - Inactive after reset; once active, writes cannot deactivate it.
// - Active bit is set by software only, cleared only by reset.
// - Write with active set and top count bit clear resets at once.
// - Stop instruction while active yields a reset instead of stopping.
// - Control register resets to 7Fh.
// - Bit 7 active bit, bits 6..0 countdown, MSB first.
//
// Register access over Wishbone was chosen for this implementation.
module sfm_watchdog
	import sfm_pkg::*;
#(
	parameter int STEP_CYCLES = SFM_STEP_CYCLES
)
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic [31:0]      wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic        stop_exec_i,
	output logic             stop_grant_o,
	output logic             chip_reset_n_o
);

	sfm_wb_req_s req;
	logic        monitor_active_bit;
	logic [6:0]  countdown;
	logic [16:0] prescale;
	logic        step_tick;
	logic        hit;
	logic        wr_ctrl;
	logic        write_fire;
	logic        expire_fire;
	logic        stop_fire;
	logic        pulse_busy;
	logic [7:0]  next_ctrl;

	assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i,
		adr: wb_adr_i, sel: wb_sel_i, dat: wb_dat_i};

	// Single-cycle classic slave; ack drops the cycle after it was given
	assign hit     = req.cyc && req.stb && !wb_ack_o;
	assign wr_ctrl = hit && req.we && req.adr == SFM_CTRL_ADDR && req.sel[0];

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= hit;
		end
	end

	// Unmapped addresses read as zero and writes to them are dropped
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_o <= 32'h0000_0000;
		end else if (hit && !req.we) begin
			if (req.adr == SFM_CTRL_ADDR) begin
				wb_dat_o <= {24'h00_0000, monitor_active_bit, countdown};
			end else begin
				wb_dat_o <= 32'h0000_0000;
			end
		end
	end

	// Merged write value: the active bit can only be ORed in
	assign next_ctrl = {monitor_active_bit | req.dat[SFM_ACTIVE_BIT],
		req.dat[SFM_TOP_BIT:0]};

	// Step prescaler; restarted by every control write
	always_ff @(posedge clk_i) begin
		if (rst_i || wr_ctrl) begin
			prescale <= 17'h0_0000;
		end else if (step_tick) begin
			prescale <= 17'h0_0000;
		end else begin
			prescale <= prescale + 17'h0_0001;
		end
	end

	assign step_tick = (prescale == 17'(STEP_CYCLES - 1));

	// Active bit: cleared only by reset, never by a write
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			monitor_active_bit <= SFM_CTRL_RESET[SFM_ACTIVE_BIT];
		end else if (wr_ctrl) begin
			monitor_active_bit <= next_ctrl[SFM_ACTIVE_BIT];
		end
	end

	// Countdown field; a write wins over a coincident decrement
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			countdown <= SFM_CTRL_RESET[SFM_TOP_BIT:0];
		end else if (wr_ctrl) begin
			countdown <= next_ctrl[SFM_TOP_BIT:0];
		end else if (step_tick) begin
			countdown <= countdown - 7'h01;
		end
	end

	// Reset sources; expiry and stop only while active, a write also when it sets active
	assign expire_fire = monitor_active_bit && step_tick && !wr_ctrl &&
		countdown == SFM_COUNT_EDGE;
	assign write_fire  = wr_ctrl && next_ctrl[SFM_ACTIVE_BIT] &&
		!next_ctrl[SFM_TOP_BIT];
	assign stop_fire   = monitor_active_bit && stop_exec_i;

	// Stop is granted only when the monitor cannot turn it into a reset
	assign stop_grant_o = stop_exec_i && !monitor_active_bit;

	sfm_pulse_gen u_pulse (
		.clk_i     (clk_i),
		.rst_i     (rst_i),
		.trigger_i (expire_fire || write_fire || stop_fire),
		.reset_n_o (chip_reset_n_o),
		.busy_o    (pulse_busy)
	);

	// Busy is informational; the chip reset pin returns high by itself once the pulse counter runs out
	logic unused_busy;
	assign unused_busy = pulse_busy;

endmodule

// ### verif/sfm_watchdog_chk.sv
module sfm_watchdog_chk (
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	input wire logic        stop_exec_i,
	input wire logic        stop_grant_o,
	input wire logic        chip_reset_n_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// Bus answers exactly one cycle after a request is taken
	AST_ACK: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack late");
	AST_ACK_DROP: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held");
	AST_ACK_CAUSE: assert property ($rose(wb_ack_o) |-> $past(wb_stb_i))
		else $error("stray ack");
	AST_HI_ZERO: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
		else $error("upper bytes set");
	// Stop while active must turn into a reset, never a grant
	AST_STOP_RST: assert property (stop_exec_i && !stop_grant_o |=> !chip_reset_n_o)
		else $error("stop no reset");
	AST_NO_GRANT: assert property (!stop_exec_i |-> !stop_grant_o)
		else $error("grant w/o stop");
	AST_PULSE: assert property ($fell(chip_reset_n_o) |=> !chip_reset_n_o [*8])
		else $error("pulse short");
	AST_PULSE_LEN: assert property ($rose(chip_reset_n_o) |-> $past(!chip_reset_n_o, 8))
		else $error("pulse short");
	cover property (stop_exec_i && !stop_grant_o);
	cover property ($fell(chip_reset_n_o));
	cover property (stop_grant_o);
endmodule

// ### verif/sfm_watchdog_tb_top.sv
module sfm_watchdog_tb_top import sfm_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;
	logic        clk_i = 0, rst_i = 1, stp = 0, ack, grant, crn;
	logic [31:0] rd;
	sfm_wb_req_s q = '0;
	// Write 3Fh, write adr/data, read back control
	logic [23:0] rows [3] = '{24'h0c7f7f, 24'h10003f, 24'h0c2a2a};
	int          failures = 0, n_compared = 0;
	always #2.5 clk_i = ~clk_i;
	sfm_watchdog #(.STEP_CYCLES(8)) dut (.clk_i(clk_i), .rst_i(rst_i),
		.wb_cyc_i(q.cyc), .wb_stb_i(q.stb), .wb_we_i(q.we), .wb_adr_i(q.adr),
		.wb_sel_i(q.sel), .wb_dat_i(q.dat), .wb_dat_o(rd), .wb_ack_o(ack),
		.stop_exec_i(stp), .stop_grant_o(grant), .chip_reset_n_o(crn));
	task chk(string s, logic [31:0] e, logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			failures++;
			$display("BAD %s exp %h got %h", s, e, g);
		end
	endtask
	// Request held until ack is sampled, then one idle cycle
	task bus(logic w, logic [7:0] a, logic [7:0] d);
		q <= '{1'b1, 1'b1, w, a, 4'hf, {24'h0, d}};
		do @(posedge clk_i); while (ack !== 1'b1);
		q <= '0;
		@(posedge clk_i);
	endtask
	task end_of_test;
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	// Reads come within a few cycles of a write or a reset, before any step
	initial begin
		repeat (12) @(posedge clk_i);
		rst_i <= 0;
		bus(0, 8'h0c, 8'h00);
		chk("reset", 32'h7f, rd);
		foreach (rows[i]) begin
			bus(1, 8'h0c, 8'h3f);
			bus(1, rows[i][23:16], rows[i][15:8]);
			bus(0, 8'h0c, 8'h00);
			chk("row", {24'h0, rows[i][7:0]}, rd);
			chk("idle", 1, crn);
		end
		bus(0, 8'h10, 8'h00);
		chk("unmapped", 0, rd);
		$display("regs done");
		bus(1, 8'h0c, 8'hc1);
		repeat (13) @(posedge clk_i);
		chk("early", 1, crn);
		repeat (6) @(posedge clk_i);
		chk("expiry", 0, crn);
		repeat (110) @(posedge clk_i);
		// Active set with top bit clear is a deliberate software reset
		bus(1, 8'h0c, 8'h85);
		@(posedge clk_i);
		chk("swrst", 0, crn);
		// Writing the active bit as zero must not clear it
		bus(1, 8'h0c, 8'h45);
		bus(0, 8'h0c, 8'h00);
		chk("sticky", 32'hc5, rd);
		stp <= 1;
		@(posedge clk_i);
		chk("stop", 0, grant);
		rst_i <= 1;
		repeat (3) @(posedge clk_i);
		rst_i <= 0;
		@(posedge clk_i);
		chk("grant", 1, grant);
		bus(0, 8'h0c, 8'h00);
		chk("rearm", 32'h7f, rd);
		$display("timing done");
		end_of_test;
	end
	// Whole run is a few hundred cycles
	initial begin
		#20000;
		failures++;
		end_of_test;
	end
endmodule
bind sfm_watchdog sfm_watchdog_chk chk (.*);
